// ==== rtl/mode_regs_pkg.sv ====
// Purpose: Shared constants and types for the mode, reserved and null
//          registers at the top of the control register map.
// Assumes: Registers are 16 bits wide and addressed by a 4-bit index.
// Notes:   Offsets are register indices on the serial register port.
//
// Contract
// - Mode bit 0 set puts the analog audio test mode on.
// - Mode bit 1 set puts the analog telecom test mode on.
// - Mode bits 5..2 pick one built-in production test mode.
// - Test bits 5..0 change only while the test pin is high.
// - Any active test mode alters normal behaviour; software keeps them clear.
// - Mode bit 12 puts audio and telecom valid flags in dynamic mode.
// - Mode bit 13 set disables audio input offset cancelling.
// - Mode bits 14 and 15 are plain read/write special-function bits.
// - Register 14 is reserved: reads give zero, writes do nothing.
// - Register 15 is read-only and always returns all ones.

package mode_regs_pkg;

  // ==========================================================================
  // Register indices
  localparam logic [3:0]  ADDR_MODE_CONTROL   = 4'hD;
  localparam logic [3:0]  ADDR_RESERVED       = 4'hE;
  localparam logic [3:0]  ADDR_ALL_ONES       = 4'hF;

  // ==========================================================================
  // Mode register field positions
  localparam int          POS_AUD_TEST        = 0;
  localparam int          POS_TEL_TEST        = 1;
  localparam int          POS_PROD_LO         = 2;
  localparam int          POS_PROD_HI         = 5;
  localparam int          POS_DYN_VFLAG       = 12;
  localparam int          POS_OFF_CAN_DIS     = 13;
  localparam int          POS_SPECIAL_LO      = 14;
  localparam int          POS_SPECIAL_HI      = 15;

  // ==========================================================================
  // Masks and values
  localparam logic [15:0] MODE_RESET          = 16'h0000;
  localparam logic [15:0] MASK_TEST_BITS      = 16'h003F;
  localparam logic [15:0] MASK_FREE_BITS      = 16'hF000;
  localparam logic [15:0] ALL_ONES_VALUE      = 16'hFFFF;
  localparam logic [15:0] RESERVED_READ       = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ       = 16'h0000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } acc_kind_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        aud_test;
    logic        tel_test;
    logic [3:0]  prod_test_mode;
    logic        dyn_vflag_ena;
    logic        aud_off_can_dis;
    logic [1:0]  special_fn;
  } mode_ctl_t;

endpackage : mode_regs_pkg

// ==== rtl/mode_bits_store.sv ====
// Purpose: Sixteen mode bits, each written only where its mask bit is set.
// Assumes: Synchronous active-high reset; one clock.
// Notes:   Masked-off bits hold their value on a write.

`timescale 1ns/1ps
`default_nettype none

module mode_bits_store
  import mode_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Write port
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_mask_i,
  input  wire logic [15:0] wr_data_i,
  // Stored bits
  output logic      [15:0] bits_o
);

  logic [15:0] bits_ff;

  // ==========================================================================
  // One flip-flop per bit
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          bits_ff[gi] <= MODE_RESET[gi];
        end else if (wr_en_i && wr_mask_i[gi]) begin
          bits_ff[gi] <= wr_data_i[gi];
        end
      end
    end
  endgenerate

  assign bits_o = bits_ff;

endmodule : mode_bits_store

`default_nettype wire

// ==== rtl/mode_test_null_registers.sv ====
// Purpose: Mode register, reserved slot and constant all-ones register
//          behind the chip's serial register port.
// Assumes: Register requests arrive already decoded from the serial bus as
//          one-cycle strobes synchronous to clk_sys_i; test pin is synchronous.
// Notes:   Reads answer one cycle after the request; writes land at the
//          edge that takes them.

`timescale 1ns/1ps
`default_nettype none

module mode_test_null_registers
  import mode_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Register request from the serial interface
  input  wire reg_req_t    reg_req_i,
  // Test pin
  input  wire logic        test_pin_i,
  // Register answer
  output logic      [15:0] rd_data_o,
  output logic             rd_ack_o,
  output logic             wr_ack_o,
  output logic             addr_hit_o,
  output logic             test_wr_blocked_o,
  // Mode controls to the analog and codec logic
  output var mode_ctl_t    mode_ctl_o,
  output logic      [15:0] prod_test_sel_o,
  output logic             test_active_o,
  output logic             aud_dyn_vflag_o,
  output logic             tel_dyn_vflag_o,
  output logic             aud_off_can_en_o
);

  // ==========================================================================
  // Request decode
  acc_kind_t   acc_kind;
  logic        sel_mode;
  logic        sel_rsvd;
  logic        sel_ones;
  logic        sel_any;

  always_comb begin
    if (reg_req_i.wr) begin
      acc_kind = ACC_WRITE;
    end else if (reg_req_i.rd) begin
      acc_kind = ACC_READ;
    end else begin
      acc_kind = ACC_IDLE;
    end
  end

  always_comb begin
    sel_mode = 1'b0;
    sel_rsvd = 1'b0;
    sel_ones = 1'b0;
    if (reg_req_i.addr == ADDR_MODE_CONTROL) begin
      sel_mode = 1'b1;
    end else if (reg_req_i.addr == ADDR_RESERVED) begin
      sel_rsvd = 1'b1;
    end else if (reg_req_i.addr == ADDR_ALL_ONES) begin
      sel_ones = 1'b1;
    end
  end

  assign sel_any = sel_mode | sel_rsvd | sel_ones;

  // ==========================================================================
  // Mode register write gating
  // Test bits are guarded by the pin so stray software writes can never
  // knock a shipped part into test mode; undefined bits have no storage
  // enable at all, so they stay zero forever.
  logic        mode_wr_en;
  logic [15:0] mode_wr_mask;
  logic [15:0] mode_bits;
  logic        test_bits_touched;

  assign mode_wr_en = (acc_kind == ACC_WRITE) && sel_mode;

  always_comb begin
    mode_wr_mask = MASK_FREE_BITS;
    if (test_pin_i) begin
      mode_wr_mask = MASK_FREE_BITS | MASK_TEST_BITS;
    end
  end

  // A write that tries to change a test bit while the pin is low
  assign test_bits_touched =
    |((reg_req_i.wdata ^ mode_bits) & MASK_TEST_BITS);

  mode_bits_store u_mode_bits (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (mode_wr_en),
    .wr_mask_i (mode_wr_mask),
    .wr_data_i (reg_req_i.wdata),
    .bits_o    (mode_bits)
  );

  // ==========================================================================
  // Read data selection
  logic [15:0] nxt_rd_data;
  logic [15:0] mode_readback;

  // Undefined bits have no flip-flop enable, but mask anyway for safety
  assign mode_readback = mode_bits & (MASK_FREE_BITS | MASK_TEST_BITS);

  always_comb begin
    nxt_rd_data = UNMAPPED_READ;
    if (sel_mode) begin
      nxt_rd_data = mode_readback;
    end else if (sel_rsvd) begin
      nxt_rd_data = RESERVED_READ;
    end else if (sel_ones) begin
      nxt_rd_data = ALL_ONES_VALUE;
    end
  end

  // ==========================================================================
  // Read answer
  logic [15:0] rd_data_ff;
  logic        rd_ack_ff;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_data_ff <= UNMAPPED_READ;
      rd_ack_ff  <= 1'b0;
    end else begin
      rd_ack_ff <= (acc_kind == ACC_READ);
      if (acc_kind == ACC_READ) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign rd_data_o = rd_data_ff;
  assign rd_ack_o  = rd_ack_ff;

  // ==========================================================================
  // Write answer and status
  // Writes to register 15 and 14 are acknowledged but discarded, so the
  // controller never stalls on a read-only slot.
  logic        wr_ack_ff;
  logic        addr_hit_ff;
  logic        test_wr_blocked_ff;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ack_ff <= 1'b0;
    end else begin
      wr_ack_ff <= (acc_kind == ACC_WRITE);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      addr_hit_ff <= 1'b0;
    end else begin
      addr_hit_ff <= (acc_kind != ACC_IDLE) && sel_any;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      test_wr_blocked_ff <= 1'b0;
    end else begin
      test_wr_blocked_ff <= mode_wr_en && !test_pin_i
                            && test_bits_touched;
    end
  end

  assign wr_ack_o          = wr_ack_ff;
  assign addr_hit_o        = addr_hit_ff;
  assign test_wr_blocked_o = test_wr_blocked_ff;

  // ==========================================================================
  // Field split toward the analog and codec blocks
  always_comb begin
    mode_ctl_o.aud_test        = mode_bits[POS_AUD_TEST];
    mode_ctl_o.tel_test        = mode_bits[POS_TEL_TEST];
    mode_ctl_o.prod_test_mode  = mode_bits[POS_PROD_HI:POS_PROD_LO];
    mode_ctl_o.dyn_vflag_ena   = mode_bits[POS_DYN_VFLAG];
    mode_ctl_o.aud_off_can_dis = mode_bits[POS_OFF_CAN_DIS];
    mode_ctl_o.special_fn      =
      mode_bits[POS_SPECIAL_HI:POS_SPECIAL_LO];
  end

  // ==========================================================================
  // Production test decode
  // Code 0 means no production test; each other code drives one select
  // line so the test logic needs no local decoder.
  logic [3:0] prod_code;

  assign prod_code = mode_bits[POS_PROD_HI:POS_PROD_LO];

  genvar gs;
  generate
    for (gs = 0; gs < 16; gs++) begin : g_prod_sel
      if (gs == 0) begin : g_none
        assign prod_test_sel_o[gs] = 1'b0;
      end else begin : g_code
        assign prod_test_sel_o[gs] = (prod_code == 4'(gs));
      end
    end
  endgenerate

  // ==========================================================================
  // Functional alteration flag
  // Downstream logic uses this to leave normal operation; it is only a
  // summary, the individual selects above still steer each test.
  assign test_active_o = mode_bits[POS_AUD_TEST]
                         | mode_bits[POS_TEL_TEST]
                         | (prod_code != 4'h0);

  // ==========================================================================
  // Valid flag mode and offset cancelling
  // One bit moves both flags so the two codecs can never disagree.
  assign aud_dyn_vflag_o  = mode_bits[POS_DYN_VFLAG];
  assign tel_dyn_vflag_o  = mode_bits[POS_DYN_VFLAG];
  assign aud_off_can_en_o = !mode_bits[POS_OFF_CAN_DIS];

endmodule : mode_test_null_registers

`default_nettype wire

// ==== sim/mode_regs_asserts.sv ====
// Purpose: Port-level checks of the mode, reserved and null registers.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound onto the register block below.
`timescale 1ns/1ps
`default_nettype none
module mode_regs_asserts
  import mode_regs_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire reg_req_t    reg_req_i,
  input wire logic        test_pin_i,
  // Outputs watched
  input wire logic [15:0] rd_data_o,
  input wire logic        rd_ack_o,
  input wire mode_ctl_t   mode_ctl_o,
  input wire logic        test_active_o,
  input wire logic        aud_dyn_vflag_o,
  input wire logic        tel_dyn_vflag_o,
  input wire logic        aud_off_can_en_o
);
  // ==========================================================================
  // Checks
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic rd_q;
  logic wr_m;
  // Write wins when both strobes are up, so a read only counts alone
  assign rd_q = reg_req_i.rd & ~reg_req_i.wr;
  assign wr_m = reg_req_i.wr & (reg_req_i.addr == ADDR_MODE_CONTROL);
  chk_read_ack: assert property (rd_q |=> rd_ack_o)
    else $error("read not acknowledged");
  chk_null_value: assert property (
    rd_q && reg_req_i.addr == ADDR_ALL_ONES |=> rd_data_o == 16'hFFFF)
    else $error("null register read wrong");
  chk_reserved_zero: assert property (
    rd_q && reg_req_i.addr == ADDR_RESERVED |=> rd_data_o == 16'h0000)
    else $error("reserved register read wrong");
  chk_free_bits: assert property (
    rd_q && reg_req_i.addr == ADDR_MODE_CONTROL |=> rd_data_o[11:6] == 6'h00)
    else $error("undefined mode bits not zero");
  chk_test_lock: assert property (
    wr_m && !test_pin_i |=> $stable(mode_ctl_o[9:4]))
    else $error("test bits changed with pin low");
  chk_test_write: assert property (
    wr_m && test_pin_i |=> mode_ctl_o[9:4] == $past({reg_req_i.wdata[0],
    reg_req_i.wdata[1], reg_req_i.wdata[5:2]}))
    else $error("test bits not written");
  chk_vflag_both: assert property (wr_m |=>
    aud_dyn_vflag_o == $past(reg_req_i.wdata[12])
    && tel_dyn_vflag_o == $past(reg_req_i.wdata[12]))
    else $error("valid flag modes wrong");
  chk_offcan_inv: assert property (
    wr_m |=> aud_off_can_en_o == !$past(reg_req_i.wdata[13]))
    else $error("offset cancel control wrong");
  chk_special_rw: assert property (
    wr_m |=> mode_ctl_o.special_fn == $past(reg_req_i.wdata[15:14]))
    else $error("special bits not written");
  chk_test_active: assert property (
    test_active_o == (|mode_ctl_o[9:4]))
    else $error("test active flag wrong");
  cover property (wr_m && !test_pin_i);
  cover property (rd_q && reg_req_i.addr == ADDR_ALL_ONES);
  cover property ($rose(test_active_o));
endmodule : mode_regs_asserts
bind mode_test_null_registers mode_regs_asserts mode_regs_asserts_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i),
  .test_pin_i(test_pin_i), .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o),
  .mode_ctl_o(mode_ctl_o), .test_active_o(test_active_o),
  .aud_dyn_vflag_o(aud_dyn_vflag_o), .tel_dyn_vflag_o(tel_dyn_vflag_o),
  .aud_off_can_en_o(aud_off_can_en_o));
`default_nettype wire

// ==== sim/sys_ctl_model.sv ====
// Purpose: System controller issuing decoded register requests.
// Assumes: Requests change on falling edges, one strobe cycle each.
// Notes:   Data lines carry an inverted pattern once released.
`timescale 1ns/1ps
`default_nettype none
module sys_ctl_model
  import mode_regs_pkg::*;
(
  // Clock and answer
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] rd_data_o,
  input  wire logic        rd_ack_o,
  input  wire logic        wr_ack_o,
  // Request
  output var  reg_req_t    req_o
);
  // ==========================================================================
  // Transfer
  initial req_o = '0;
  task automatic xfer(input logic [3:0] a, input logic w,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic k);
    @(negedge clk_sys_i);
    req_o = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clk_sys_i);
    // Answer pulses stand only in the cycle after the taking edge
    q = rd_data_o;
    k = w ? wr_ack_o : rd_ack_o;
    req_o.wr = 1'b0;
    req_o.rd = 1'b0;
    req_o.wdata = ~d;
  endtask : xfer
endmodule : sys_ctl_model
`default_nettype wire

// ==== sim/test_mode_test_null_registers.sv ====
// Purpose: Self-checking bench for the mode, reserved and null registers.
// Assumes: The controller model serialises requests.
// Notes:   Test pin is driven on falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_mode_test_null_registers
  import mode_regs_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  logic        clk_sys_i, sys_rst_i, test_pin_i, k;
  logic        rd_ack_o, wr_ack_o, test_active_o, aud_off_can_en_o;
  logic        aud_dyn_vflag_o, tel_dyn_vflag_o;
  logic        addr_hit_o, test_wr_blocked_o;
  logic [15:0] rd_data_o, prod_test_sel_o, q;
  reg_req_t    req;
  mode_ctl_t   mode_ctl_o;
  int          err_count, check_count;
  mode_test_null_registers mode_test_null_registers_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
    .test_pin_i(test_pin_i), .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o),
    .wr_ack_o(wr_ack_o), .addr_hit_o(addr_hit_o),
    .test_wr_blocked_o(test_wr_blocked_o),
    .mode_ctl_o(mode_ctl_o), .prod_test_sel_o(prod_test_sel_o),
    .test_active_o(test_active_o), .aud_dyn_vflag_o(aud_dyn_vflag_o),
    .tel_dyn_vflag_o(tel_dyn_vflag_o), .aud_off_can_en_o(aud_off_can_en_o));
  sys_ctl_model sys_ctl_model_inst (.clk_sys_i(clk_sys_i),
    .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o), .wr_ack_o(wr_ack_o),
    .req_o(req));
  // ==========================================================================
  // Tasks
  task automatic acc(input logic [3:0] a, input logic w, input logic [15:0] d);
    sys_ctl_model_inst.xfer(a, w, d, q, k);
    `CHK("ack", 1'b1, k)
  endtask : acc
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    acc(a, 1'b0, 16'h0000);
    `CHK("rd_data", e, q)
  endtask : rd_chk
  task automatic t_reset();
    rd_chk(ADDR_MODE_CONTROL, 16'h0000);
    `CHK("off_can_en", 1'b1, aud_off_can_en_o)
    `CHK("test_active", 1'b0, test_active_o)
    $display("test reset done");
  endtask : t_reset
  task automatic t_fixed();
    acc(ADDR_ALL_ONES, 1'b1, 16'h0000);
    rd_chk(ADDR_ALL_ONES, 16'hFFFF);
    `CHK("addr_hit", 1'b1, addr_hit_o)
    acc(ADDR_RESERVED, 1'b1, 16'hFFFF);
    rd_chk(ADDR_RESERVED, 16'h0000);
    `CHK("addr_hit", 1'b1, addr_hit_o)
    rd_chk(ADDR_MODE_CONTROL, 16'h0000);
    rd_chk(4'h3, 16'h0000);
    `CHK("addr_hit", 1'b0, addr_hit_o)
    $display("test fixed registers done");
  endtask : t_fixed
  task automatic t_modes();
    test_pin_i = 1'b1;
    acc(ADDR_MODE_CONTROL, 1'b1, 16'h0001);
    `CHK("aud_test", 1'b1, mode_ctl_o.aud_test)
    acc(ADDR_MODE_CONTROL, 1'b1, 16'h0002);
    `CHK("aud_tel", 2'b01, {mode_ctl_o.aud_test, mode_ctl_o.tel_test})
    for (int i = 1; i < 16; i++) begin
      acc(ADDR_MODE_CONTROL, 1'b1, {10'h000, i[3:0], 2'b00});
      `CHK("prod_sel", 16'h0001 << i, prod_test_sel_o)
      `CHK("test_active", 1'b1, test_active_o)
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_pin_low();
    acc(ADDR_MODE_CONTROL, 1'b1, 16'h0001);
    test_pin_i = 1'b0;
    acc(ADDR_MODE_CONTROL, 1'b1, 16'hFFFF);
    `CHK("wr_blocked", 1'b1, test_wr_blocked_o)
    rd_chk(ADDR_MODE_CONTROL, 16'hF001);
    `CHK("vflags", 2'b11, {aud_dyn_vflag_o, tel_dyn_vflag_o})
    `CHK("off_can_en", 1'b0, aud_off_can_en_o)
    `CHK("test_active", 1'b1, test_active_o)
    test_pin_i = 1'b1;
    acc(ADDR_MODE_CONTROL, 1'b1, 16'h0000);
    `CHK("test_active", 1'b0, test_active_o)
    $display("test pin low done");
  endtask : t_pin_low
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // Run
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    err_count++;
    report_and_stop();
  end
  initial begin
    sys_rst_i = 1'b1;
    test_pin_i = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (16) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_fixed();
    t_modes();
    t_pin_low();
    report_and_stop();
  end
endmodule : test_mode_test_null_registers
`default_nettype wire
